// ---- tb_top.sv ----
// self-checking bench for the uart line core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_FCR  = 8'h08;
  localparam logic [7:0] A_LCR  = 8'h0c;
  localparam logic [7:0] A_LSR  = 8'h14;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        rx_dma_req;
  logic        tx_dma_req;
  int          fail_count;
  int          n_tests;
  logic [7:0]  b [4];
  logic [7:0]  rd;
  logic        err;

  uart_fifo_line_core i_uart_fifo_line_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));
  uart_remote_model i_uart_remote_model (.pclk(pclk), .txd(txd), .rxd(rxd));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
    end
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, rd, err);
    chk(rd, exp, "register read");
  endtask

  task automatic wait_tx(input int cnt);
    for (int i = 0; i < 3000 && i_uart_remote_model.rx_q.size() < cnt; i++) @(posedge pclk);
    if (i_uart_remote_model.rx_q.size() < cnt) begin
      fail_count++;
    end
    // let the stop bit finish before status is read
    repeat (16) @(posedge pclk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    end_sim();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h4441));
    rd_chk(A_LSR, 8'h60);
    rd_chk(A_LCR, 8'h00);
    apb(1'b0, 8'h40, 8'h00, rd, err);
    chk({7'h0, err}, 8'h01, "unmapped error");
    $display("test reset done");
    wr(A_LCR, 8'h03);
    wr(A_FCR, 8'h01);
    foreach (b[i]) begin
      b[i] = 8'($urandom);
      wr(A_DATA, b[i]);
    end
    rd_chk(A_LSR, 8'h00);
    wait_tx(4);
    foreach (b[i]) chk(i_uart_remote_model.rx_q[i], b[i], "sent byte");
    rd_chk(A_LSR, 8'h60);
    $display("test transmit done");
    for (int i = 0; i < 3; i++) i_uart_remote_model.send(b[i], 1'b1);
    rd_chk(A_LSR, 8'h61);
    rd_chk(A_LSR, 8'h61);
    chk({7'h0, rx_dma_req}, 8'h01, "rx dma request");
    for (int i = 0; i < 3; i++) rd_chk(A_DATA, b[i]);
    rd_chk(A_LSR, 8'h60);
    $display("test receive done");
    i_uart_remote_model.send(b[3] | 8'h01, 1'b0);
    rd_chk(A_LSR, 8'he9);
    rd_chk(A_DATA, b[3] | 8'h01);
    rd_chk(A_LSR, 8'h60);
    $display("test framing done");
    i_uart_remote_model.send(b[0], 1'b1);
    wr(A_FCR, 8'h03);
    rd_chk(A_LSR, 8'h60);
    wr(A_FCR, 8'h00);
    i_uart_remote_model.send(b[1], 1'b1);
    i_uart_remote_model.send(b[2], 1'b1);
    rd_chk(A_LSR, 8'h63);
    rd_chk(A_LSR, 8'h61);
    rd_chk(A_DATA, b[2]);
    $display("test overrun done");
    wr(A_FCR, 8'h09);
    i_uart_remote_model.send(b[0], 1'b1);
    chk({7'h0, rx_dma_req}, 8'h00, "rx dma below trigger");
    chk({7'h0, tx_dma_req}, 8'h01, "tx dma free spaces");
    rd_chk(A_DATA, b[0]);
    $display("test dma mode done");
    wr(A_LCR, 8'h02);
    wr(A_DATA, 8'h00);
    wait_tx(5);
    chk(i_uart_remote_model.rx_q[4], 8'h80, "seven bit frame");
    $display("test word length done");
    wr(A_LCR, 8'h43);
    repeat (2) @(posedge pclk);
    chk({7'h0, txd}, 8'h00, "break level");
    wr(A_LCR, 8'h03);
    repeat (2) @(posedge pclk);
    chk({7'h0, txd}, 8'h01, "idle level");
    $display("test break done");
    end_sim();
  end
endmodule

// ---- uart_core_pkg.sv ----
// constants, state codes and operation overview for the uart line core
// Overview of operation
// - serial input shifted in, each finished character stored in 64-entry receive fifo unless it is full
// - with fifos off only entry zero is used; new characters overwrite unread ones
// - host bytes go to 64-entry transmit fifo, then shift register, then serial out
// - fifo control bit 0 enables or disables both fifos together
// - fifo control bit 1 written high empties receive fifo; self clearing
// - fifo control bit 2 written high empties transmit fifo; self clearing
// - fifo control bit 3 picks dma signalling mode 0 or 1
// - fifo control bits 5:4 pick transmit trigger 8, 16, 32 or 56 spaces
// - fifo control bits 7:6 pick receive trigger 8, 16, 56 or 60 characters
// - transmit trigger field written and used only while enhanced bit 4 set
// - line control bits 1:0 pick 5 to 8 data bits both ways
// - line control bit 2 picks one stop bit, or 1.5 / 2 stop bits
// - line control bit 3 adds parity on send and checks it on receive
// - bit 4 picks odd or even; bit 5 forces parity to inverse of bit 4
// - line control bit 6 holds serial output low as a break
// - line control bit 7 maps shared addresses to divisor latch bytes
// - status bit 0 shows data present; bit 1 shows receive overrun happened
// - status bits 4:2 show break, framing, parity flags of head character
// - status bit 5 shows transmit fifo empty; bit 6 adds shift register empty
// - status bit 7 high while any stored character carries an error flag
// - status read leaves receive read pointer alone; data read advances it
// - enhanced feature register reachable only while line control holds 8'hbf
package uart_core_pkg;
  localparam int unsigned FIFO_AW     = 6;
  localparam logic [6:0]  FIFO_DEPTH  = 7'h40;
  localparam logic [2:0]  IDX_DATA    = 3'h0;
  localparam logic [2:0]  IDX_DLH     = 3'h1;
  localparam logic [2:0]  IDX_FCR     = 3'h2;
  localparam logic [2:0]  IDX_LCR     = 3'h3;
  localparam logic [2:0]  IDX_LSR     = 3'h5;
  localparam int unsigned FCR_EN      = 0;
  localparam int unsigned FCR_RXCLR   = 1;
  localparam int unsigned FCR_TXCLR   = 2;
  localparam int unsigned FCR_DMA     = 3;
  localparam int unsigned LCR_STOP    = 2;
  localparam int unsigned LCR_PEN     = 3;
  localparam int unsigned LCR_EVEN    = 4;
  localparam int unsigned LCR_STICK   = 5;
  localparam int unsigned LCR_BREAK   = 6;
  localparam int unsigned LCR_DLAB    = 7;
  localparam int unsigned EFR_ENH     = 4;
  localparam logic [7:0]  LCR_EFR_KEY = 8'hbf;
  localparam logic [7:0]  LCR_RST     = 8'h00;
  localparam logic [15:0] DIV_RST     = 16'h0001;
  localparam logic [5:0]  BIT_LAST    = 6'h0f;
  localparam logic [5:0]  HALF_LAST   = 6'h07;
  localparam logic [5:0]  STOP15_LAST = 6'h17;
  localparam logic [5:0]  STOP2_LAST  = 6'h1f;
  localparam logic [3:0][6:0] TX_TRIG = {7'h38, 7'h20, 7'h10, 7'h08};
  localparam logic [3:0][6:0] RX_TRIG = {7'h3c, 7'h38, 7'h10, 7'h08};
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_DATA  = 5'h04,
    ST_PAR   = 5'h08,
    ST_STOP  = 5'h10
  } ser_state_e;
endpackage

// ---- uart_fifo_line_core.sv ----
// uart channel: apb registers, 64-entry fifos, serial transmitter and receiver
module uart_fifo_line_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             rx_dma_req,
  output logic             tx_dma_req
);
  typedef struct packed {
    logic                      rx_s1;
    logic                      rx_s2;
    logic                      rx_prev;
    logic                      pready;
    logic                      pslverr;
    logic [7:0]                prdata;
    logic                      fifo_en;
    logic                      dma_mode;
    logic [1:0]                tx_trig;
    logic [1:0]                rx_trig;
    logic [7:0]                line_control;
    logic [7:0]                enhanced_feature_register;
    logic [15:0]               divisor;
    logic [15:0]               baud_cnt;
    logic                      tick;
    logic [5:0]                rx_wp;
    logic [5:0]                rx_rp;
    logic [6:0]                rx_cnt;
    logic [6:0]                err_cnt;
    logic                      overrun;
    logic [5:0]                tx_wp;
    logic [5:0]                tx_rp;
    logic [6:0]                tx_cnt;
    uart_core_pkg::ser_state_e tx_st;
    logic [5:0]                tx_tk;
    logic [2:0]                tx_bit;
    logic [7:0]                tx_sh;
    logic                      tx_pbit;
    logic                      txd;
    uart_core_pkg::ser_state_e rx_st;
    logic [5:0]                rx_tk;
    logic [2:0]                rx_bit;
    logic [7:0]                rx_sh;
    logic                      rx_pbit;
    logic                      rx_dma;
    logic                      tx_dma;
  } state_s;

  state_s      q;
  state_s      d;
  logic [2:0]  idx;
  logic        addr_ok;
  logic        acc_first;
  logic        wr_done;
  logic        rd_done;
  logic        efr_sel;
  logic        dlab;
  logic        lsr_rd;
  logic        rhr_rd;
  logic        thr_wr;
  logic        fcr_wr;
  logic        efr_wr;
  logic [2:0]  wl_m1;
  logic [7:0]  wl_mask;
  logic [5:0]  stop_last;
  logic [2:0]  head_flags;
  logic [7:0]  lsr_val;
  logic [7:0]  rd_val;
  logic [10:0] rx_q;
  logic [7:0]  tx_q;
  logic        rx_we;
  logic [10:0] rx_wdata;
  logic        tx_we;
  logic        rx_push;
  logic        rx_pop;
  logic        rx_full;
  logic        rx_new;
  logic        rx_over;
  logic        tx_pop;
  logic        tx_full;
  logic        tx_new;
  logic        clr_rx;
  logic        clr_tx;
  logic [7:0]  rx_char;
  logic [2:0]  rx_flags;
  logic [6:0]  rx_lim;
  logic [1:0]  tx_trig_eff;

  assign idx       = paddr[4:2];
  assign addr_ok   = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign acc_first = psel & penable & ~q.pready;
  assign wr_done   = psel & penable & q.pready & pwrite & addr_ok;
  assign rd_done   = psel & penable & q.pready & ~pwrite & addr_ok;
  assign efr_sel   = q.line_control == uart_core_pkg::LCR_EFR_KEY;
  assign dlab      = q.line_control[uart_core_pkg::LCR_DLAB];
  assign lsr_rd    = rd_done & (idx == uart_core_pkg::IDX_LSR);
  assign rhr_rd    = rd_done & (idx == uart_core_pkg::IDX_DATA) & ~dlab;
  assign thr_wr    = wr_done & (idx == uart_core_pkg::IDX_DATA) & ~dlab;
  assign fcr_wr    = wr_done & (idx == uart_core_pkg::IDX_FCR) & ~efr_sel;
  assign efr_wr    = wr_done & (idx == uart_core_pkg::IDX_FCR) & efr_sel;
  assign wl_m1     = 3'h4 + {1'b0, q.line_control[1:0]};
  assign wl_mask   = 8'hff >> (2'h3 - q.line_control[1:0]);
  assign stop_last = !q.line_control[uart_core_pkg::LCR_STOP] ? uart_core_pkg::BIT_LAST :
                     (q.line_control[1:0] == 2'h0) ? uart_core_pkg::STOP15_LAST : uart_core_pkg::STOP2_LAST;
  assign head_flags = (q.rx_cnt != 7'h00) ? rx_q[10:8] : 3'h0;
  assign lsr_val   = {q.err_cnt != 7'h00,
                      (q.tx_cnt == 7'h00) && (q.tx_st == uart_core_pkg::ST_IDLE),
                      q.tx_cnt == 7'h00, head_flags, q.overrun, q.rx_cnt != 7'h00};
  assign rx_lim    = q.fifo_en ? uart_core_pkg::FIFO_DEPTH : 7'h01;
  assign rx_char   = q.rx_sh >> (2'h3 - q.line_control[1:0]);
  assign tx_trig_eff = q.enhanced_feature_register[uart_core_pkg::EFR_ENH] ? q.tx_trig : 2'h0;

  function automatic logic par_of(input logic [7:0] v, input logic [7:0] lc);
    par_of = lc[uart_core_pkg::LCR_STICK] ? ~lc[uart_core_pkg::LCR_EVEN] :
             (^v) ^ ~lc[uart_core_pkg::LCR_EVEN];
  endfunction

  always_comb begin
    case (idx)
      uart_core_pkg::IDX_DATA: rd_val = dlab ? q.divisor[7:0] : rx_q[7:0];
      uart_core_pkg::IDX_DLH:  rd_val = dlab ? q.divisor[15:8] : 8'h00;
      uart_core_pkg::IDX_FCR:  rd_val = efr_sel ? q.enhanced_feature_register : 8'h00;
      uart_core_pkg::IDX_LCR:  rd_val = q.line_control;
      uart_core_pkg::IDX_LSR:  rd_val = lsr_val;
      default:                 rd_val = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    d.tick = 1'b0;
    rx_push = 1'b0;
    tx_pop = 1'b0;
    rx_flags = 3'h0;
    clr_rx = 1'b0;
    clr_tx = 1'b0;
    // bus slave, one wait state
    d.pready = acc_first;
    d.pslverr = acc_first & ~addr_ok;
    d.prdata = (acc_first && !pwrite && addr_ok) ? rd_val : 8'h00;
    // rx pin synchroniser
    d.rx_s1 = rxd;
    d.rx_s2 = q.rx_s1;
    d.rx_prev = q.rx_s2;
    // register writes
    if (wr_done && idx == uart_core_pkg::IDX_LCR) begin
      d.line_control = pwdata[7:0];
    end
    if (efr_wr) begin
      d.enhanced_feature_register = pwdata[7:0];
    end
    if (wr_done && dlab && idx == uart_core_pkg::IDX_DATA) begin
      d.divisor[7:0] = pwdata[7:0];
    end
    if (wr_done && dlab && idx == uart_core_pkg::IDX_DLH) begin
      d.divisor[15:8] = pwdata[7:0];
    end
    if (fcr_wr) begin
      d.fifo_en = pwdata[uart_core_pkg::FCR_EN];
      d.dma_mode = pwdata[uart_core_pkg::FCR_DMA];
      d.rx_trig = pwdata[7:6];
      if (q.enhanced_feature_register[uart_core_pkg::EFR_ENH]) begin
        d.tx_trig = pwdata[5:4];
      end
      clr_rx = pwdata[uart_core_pkg::FCR_RXCLR] | (pwdata[uart_core_pkg::FCR_EN] != q.fifo_en);
      clr_tx = pwdata[uart_core_pkg::FCR_TXCLR] | (pwdata[uart_core_pkg::FCR_EN] != q.fifo_en);
    end
    // 16x baud tick
    if (q.baud_cnt == 16'h0000) begin
      d.baud_cnt = (q.divisor == 16'h0000) ? 16'h0000 : q.divisor - 16'h0001;
      d.tick = 1'b1;
    end else begin
      d.baud_cnt = q.baud_cnt - 16'h0001;
    end
    // transmitter
    case (q.tx_st)
      uart_core_pkg::ST_IDLE: begin
        if (q.tick && q.tx_cnt != 7'h00) begin
          tx_pop = 1'b1;
          d.tx_sh = tx_q & wl_mask;
          d.tx_pbit = par_of(tx_q & wl_mask, q.line_control);
          d.tx_st = uart_core_pkg::ST_START;
          d.tx_tk = 6'h00;
        end
      end
      uart_core_pkg::ST_START: begin
        if (q.tick) begin
          d.tx_tk = q.tx_tk + 6'h01;
          if (q.tx_tk == uart_core_pkg::BIT_LAST) begin
            d.tx_tk = 6'h00;
            d.tx_bit = 3'h0;
            d.tx_st = uart_core_pkg::ST_DATA;
          end
        end
      end
      uart_core_pkg::ST_DATA: begin
        if (q.tick) begin
          d.tx_tk = q.tx_tk + 6'h01;
          if (q.tx_tk == uart_core_pkg::BIT_LAST) begin
            d.tx_tk = 6'h00;
            d.tx_sh = q.tx_sh >> 1;
            d.tx_bit = q.tx_bit + 3'h1;
            if (q.tx_bit == wl_m1) begin
              d.tx_st = q.line_control[uart_core_pkg::LCR_PEN] ? uart_core_pkg::ST_PAR : uart_core_pkg::ST_STOP;
            end
          end
        end
      end
      uart_core_pkg::ST_PAR: begin
        if (q.tick) begin
          d.tx_tk = q.tx_tk + 6'h01;
          if (q.tx_tk == uart_core_pkg::BIT_LAST) begin
            d.tx_tk = 6'h00;
            d.tx_st = uart_core_pkg::ST_STOP;
          end
        end
      end
      uart_core_pkg::ST_STOP: begin
        if (q.tick) begin
          d.tx_tk = q.tx_tk + 6'h01;
          if (q.tx_tk == stop_last) begin
            d.tx_st = uart_core_pkg::ST_IDLE;
          end
        end
      end
      default: d.tx_st = uart_core_pkg::ST_IDLE;
    endcase
    case (d.tx_st)
      uart_core_pkg::ST_START: d.txd = 1'b0;
      uart_core_pkg::ST_DATA:  d.txd = d.tx_sh[0];
      uart_core_pkg::ST_PAR:   d.txd = d.tx_pbit;
      default:                 d.txd = 1'b1;
    endcase
    if (q.line_control[uart_core_pkg::LCR_BREAK]) begin
      d.txd = 1'b0;
    end
    // receiver
    case (q.rx_st)
      uart_core_pkg::ST_IDLE: begin
        if (q.rx_prev && !q.rx_s2) begin
          d.rx_st = uart_core_pkg::ST_START;
          d.rx_tk = 6'h00;
        end
      end
      uart_core_pkg::ST_START: begin
        if (q.tick) begin
          d.rx_tk = q.rx_tk + 6'h01;
          if (q.rx_tk == uart_core_pkg::HALF_LAST) begin
            d.rx_tk = 6'h00;
            d.rx_bit = 3'h0;
            d.rx_sh = 8'h00;
            d.rx_st = q.rx_s2 ? uart_core_pkg::ST_IDLE : uart_core_pkg::ST_DATA;
          end
        end
      end
      uart_core_pkg::ST_DATA: begin
        if (q.tick) begin
          d.rx_tk = q.rx_tk + 6'h01;
          if (q.rx_tk == uart_core_pkg::BIT_LAST) begin
            d.rx_tk = 6'h00;
            d.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
            d.rx_bit = q.rx_bit + 3'h1;
            if (q.rx_bit == wl_m1) begin
              d.rx_st = q.line_control[uart_core_pkg::LCR_PEN] ? uart_core_pkg::ST_PAR : uart_core_pkg::ST_STOP;
            end
          end
        end
      end
      uart_core_pkg::ST_PAR: begin
        if (q.tick) begin
          d.rx_tk = q.rx_tk + 6'h01;
          if (q.rx_tk == uart_core_pkg::BIT_LAST) begin
            d.rx_tk = 6'h00;
            d.rx_pbit = q.rx_s2;
            d.rx_st = uart_core_pkg::ST_STOP;
          end
        end
      end
      uart_core_pkg::ST_STOP: begin
        if (q.tick) begin
          d.rx_tk = q.rx_tk + 6'h01;
          if (q.rx_tk == uart_core_pkg::BIT_LAST) begin
            rx_push = 1'b1;
            rx_flags[1] = ~q.rx_s2;
            rx_flags[0] = q.line_control[uart_core_pkg::LCR_PEN] & (q.rx_pbit != par_of(rx_char, q.line_control));
            rx_flags[2] = ~q.rx_s2 && rx_char == 8'h00 && !(q.line_control[uart_core_pkg::LCR_PEN] && q.rx_pbit);
            d.rx_st = uart_core_pkg::ST_IDLE;
          end
        end
      end
      default: d.rx_st = uart_core_pkg::ST_IDLE;
    endcase
    // receive fifo
    rx_pop = rhr_rd && q.rx_cnt != 7'h00;
    rx_full = (q.rx_cnt >= rx_lim) && !rx_pop;
    rx_new = rx_push && !rx_full;
    rx_over = rx_push && rx_full && !q.fifo_en;
    rx_we = rx_new | rx_over;
    rx_wdata = {rx_flags, rx_char};
    if (rx_new) begin
      d.rx_wp = q.fifo_en ? q.rx_wp + 6'h01 : 6'h00;
    end
    if (rx_pop) begin
      d.rx_rp = q.fifo_en ? q.rx_rp + 6'h01 : 6'h00;
    end
    d.rx_cnt = q.rx_cnt + {6'h00, rx_new} - {6'h00, rx_pop};
    d.err_cnt = q.err_cnt + {6'h00, rx_we && rx_flags != 3'h0}
                - {6'h00, (rx_pop || rx_over) && rx_q[10:8] != 3'h0};
    d.overrun = (q.overrun & ~lsr_rd) | (rx_push & rx_full);
    if (clr_rx) begin
      d.rx_wp = 6'h00;
      d.rx_rp = 6'h00;
      d.rx_cnt = 7'h00;
      d.err_cnt = 7'h00;
    end
    // transmit fifo
    tx_full = (q.tx_cnt >= rx_lim) && !tx_pop;
    tx_new = thr_wr && !tx_full;
    tx_we = tx_new | (thr_wr && !q.fifo_en);
    if (tx_new) begin
      d.tx_wp = q.fifo_en ? q.tx_wp + 6'h01 : 6'h00;
    end
    if (tx_pop) begin
      d.tx_rp = q.fifo_en ? q.tx_rp + 6'h01 : 6'h00;
    end
    d.tx_cnt = q.tx_cnt + {6'h00, tx_new} - {6'h00, tx_pop};
    if (clr_tx) begin
      d.tx_wp = 6'h00;
      d.tx_rp = 6'h00;
      d.tx_cnt = 7'h00;
    end
    // dma request levels
    if (q.dma_mode && q.fifo_en) begin
      d.rx_dma = q.rx_cnt >= uart_core_pkg::RX_TRIG[q.rx_trig];
      d.tx_dma = (uart_core_pkg::FIFO_DEPTH - q.tx_cnt) >= uart_core_pkg::TX_TRIG[tx_trig_eff];
    end else begin
      d.rx_dma = q.rx_cnt != 7'h00;
      d.tx_dma = q.tx_cnt == 7'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
      q.rx_prev <= 1'b1;
      q.txd <= 1'b1;
      q.tx_st <= uart_core_pkg::ST_IDLE;
      q.rx_st <= uart_core_pkg::ST_IDLE;
      q.line_control <= uart_core_pkg::LCR_RST;
      q.divisor <= uart_core_pkg::DIV_RST;
    end else begin
      q <= d;
    end
  end

  uart_fifo_ram #(.W(11)) rx_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (rx_we),
    .waddr   (q.rx_wp),
    .wdata   (rx_wdata),
    .raddr   (d.rx_rp),
    .rdata   (rx_q)
  );

  uart_fifo_ram #(.W(8)) tx_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (tx_we),
    .waddr   (q.tx_wp),
    .wdata   (pwdata[7:0]),
    .raddr   (d.tx_rp),
    .rdata   (tx_q)
  );

  assign prdata     = {24'h000000, q.prdata};
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign txd        = q.txd;
  assign rx_dma_req = q.rx_dma;
  assign tx_dma_req = q.tx_dma;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  rx_clear_a: assert property (fcr_wr && pwdata[uart_core_pkg::FCR_RXCLR] |=> q.rx_cnt == 7'h00 && q.err_cnt == 7'h00)
    else $error("receive fifo not emptied");
  tx_clear_a: assert property (fcr_wr && pwdata[uart_core_pkg::FCR_TXCLR] |=> q.tx_cnt == 7'h00)
    else $error("transmit fifo not emptied");
  single_entry_a: assert property (!q.fifo_en |-> q.rx_cnt <= 7'h01 && q.tx_cnt <= 7'h01)
    else $error("more than one entry with fifos off");
  break_hold_a: assert property (q.line_control[uart_core_pkg::LCR_BREAK] |=> !txd)
    else $error("break not driven low");
  lsr_keeps_ptr_a: assert property (lsr_rd |=> $stable(q.rx_rp))
    else $error("status read moved receive pointer");
  overrun_set_a: assert property (rx_push && q.rx_cnt >= rx_lim && !rx_pop |=> q.overrun)
    else $error("overrun not flagged");
  overrun_clr_a: assert property (lsr_rd && !rx_push |=> !q.overrun)
    else $error("overrun not cleared by status read");
  tx_trig_gate_a: assert property (fcr_wr && !q.enhanced_feature_register[uart_core_pkg::EFR_ENH] |=> $stable(q.tx_trig))
    else $error("transmit trigger written while locked");
  efr_lock_a: assert property (wr_done && !efr_sel |=> $stable(q.enhanced_feature_register))
    else $error("enhanced register written without key");
  data_ready_a: assert property (acc_first && !pwrite && paddr == {3'h0, uart_core_pkg::IDX_LSR, 2'h0} && q.rx_cnt != 7'h00 |=> prdata[0])
    else $error("data ready bit low with data stored");
endmodule

// ---- uart_fifo_ram.sv ----
// fifo storage with registered read data and write-through
module uart_fifo_ram #(
  parameter int unsigned W = 8
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                we,
  input  wire logic [uart_core_pkg::FIFO_AW-1:0]   waddr,
  input  wire logic [W-1:0]                        wdata,
  input  wire logic [uart_core_pkg::FIFO_AW-1:0]   raddr,
  output logic      [W-1:0]                        rdata
);
  typedef struct packed {
    logic [(1 << uart_core_pkg::FIFO_AW)-1:0][W-1:0] mem;
    logic [W-1:0]                                    rd;
  } ram_s;

  ram_s q;
  ram_s d;

  always_comb begin
    d = q;
    if (we) begin
      d.mem[waddr] = wdata;
    end
    d.rd = (we && waddr == raddr) ? wdata : q.mem[raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rd;
endmodule

// ---- uart_remote_model.sv ----
// remote serial device model: drives rxd, decodes txd at 16 clocks per bit
module uart_remote_model (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q [$];

  initial rxd = 1'b1;

  // start bit, data lsb first, chosen stop level, then idle high
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (16) @(posedge pclk);
  endtask

  // samples each bit mid cell, keeps only frames with a high stop
  initial begin : decode
    logic [7:0] d;
    forever begin
      @(negedge txd);
      repeat (24) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        d[i] = txd;
        repeat (16) @(posedge pclk);
      end
      if (txd === 1'b1) begin
        rx_q.push_back(d);
      end
    end
  end
endmodule
